// *** dcw_device_config.sv ***
// Configuration word block: loaded words, control, identification and key registers.
// Assumes an Avalon-MM master and a nonvolatile array answering one cycle after a read.
//
// The Avalon-MM slave port was left to the implementer.
`include "dcw_cfg.svh"
module dcw_device_config #(
  parameter bit HAS_TRACE = 1'b1, // Large package with trace pin
  parameter bit HAS_USB = 1'b1 // Variant with USB module
) (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire dcw_pkg::dcw_req_t avReq, // Avalon-MM request
  output dcw_pkg::dcw_rsp_t avRsp, // Avalon-MM answer
  output logic nvRead, // Array read strobe
  output logic [1:0] nvIndex, // Array word index
  input wire logic [31:0] nvData, // Array word
  input wire logic extProgRead, // Programmer asks to read flash
  input wire logic extProgWrite, // Programmer asks to modify flash
  input wire logic cpuBootWrite, // Running code asks to write boot flash
  output logic extProgGrant, // Programmer access allowed
  output logic cpuBootGrant, // Boot flash write allowed
  output logic moduleDisableWriteEn, // Module disable registers writable
  output dcw_pkg::dcw_ctl_t ctl, // Decoded configuration
  output logic configReady // Words loaded, device may leave reset
);
  import dcw_pkg::*;
  // ****************************************
  // Word loading
  // ****************************************
  logic [127:0] words;
  logic loadDone;
  dcw_nv_loader loader (
    .clk(clk),
    .rst(rst),
    .nvRead(nvRead),
    .nvIndex(nvIndex),
    .nvData(nvData),
    .words(words),
    .loadDone(loadDone)
  );
  wire [31:0] word0 = words[31:0];
  wire [31:0] word1 = words[63:32];
  wire [31:0] word2 = words[95:64];
  wire [31:0] word3 = words[127:96];
  // ****************************************
  // Protection decode
  // ****************************************
  wire codeProtect = loadDone & ~word0[`DCW_W0_CODE_PROT];
  wire bootWriteProtect = loadDone & ~word0[`DCW_W0_BOOT_WP];
  // Until loading ends every access is refused, since protection is not yet known
  assign extProgGrant = loadDone & ~codeProtect & (extProgRead | extProgWrite);
  assign cpuBootGrant = loadDone & ~bootWriteProtect & cpuBootWrite;
  // ****************************************
  // Control and key registers
  // ****************************************
  logic [31:0] control_q, control_d;
  logic [31:0] key_q, key_d;
  logic debugSeed_q;
  logic readValid_q;
  logic [31:0] readData_q;
  wire [31:0] traceMask = HAS_TRACE ? 32'hffffffff : ~(32'h1 << `DCW_CC_TRACE_EN);
  wire [31:0] ccMask = (`DCW_CC_WMASK | (32'h1 << `DCW_CC_DEBUG_EN)) & traceMask;
  wire selWord0 = (avReq.address == `DCW_OFS_WORD0);
  wire selWord1 = (avReq.address == `DCW_OFS_WORD1);
  wire selWord2 = (avReq.address == `DCW_OFS_WORD2);
  wire selWord3 = (avReq.address == `DCW_OFS_WORD3);
  wire selControl = (avReq.address == `DCW_OFS_CONTROL);
  wire selPart = (avReq.address == `DCW_OFS_PARTID);
  wire selKey = (avReq.address == `DCW_OFS_KEY);
  wire selStat = (avReq.address == `DCW_OFS_LOADSTAT);
  // Reads wait one cycle so data come from a flop; writes finish at once
  wire readTake = avReq.read & readValid_q;
  wire writeTake = avReq.write;
  wire [31:0] usbMask = HAS_USB ? 32'hffffffff :
    ~((32'h1 << `DCW_W2_USB_PLL_EN) | (32'h7 << `DCW_W2_USB_DIV_LO));
  wire [31:0] partWord = {`DCW_REVISION, `DCW_PART_ID, 16'h0000};
  // Words show zero until loaded; the array content decides them, not a constant
  // Control reads the whole flop: writes touch only ccMask bits, so unused bits stay zero
  // while the fixed bit 1 of the reset value still reads back
  wire [31:0] readMux =
    selWord0 ? (loadDone ? word0 : 32'h0) :
    selWord1 ? (loadDone ? word1 : 32'h0) :
    selWord2 ? (loadDone ? (word2 & usbMask) : 32'h0) :
    selWord3 ? (loadDone ? word3 : 32'h0) :
    selControl ? control_q :
    selPart ? partWord :
    selKey ? key_q :
    selStat ? {31'h0, loadDone} :
    32'h0;
  // Config words take no writes; the write is acknowledged and dropped
  always_comb
  begin
    control_d = control_q;
    key_d = key_q;
    if (writeTake && selControl)
      control_d = (control_q & ~ccMask) | (avReq.writedata & ccMask);
    if (writeTake && selKey)
      key_d = avReq.writedata;
    // Word 0 seeds debug enable once, after load; software may change it later
    if (loadDone && !debugSeed_q)
    begin
      control_d[`DCW_CC_DEBUG_EN] = word0[`DCW_W0_DEBUG_EN];
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_q <= `DCW_CC_RESET;
      key_q <= `DCW_KEY_RESET;
      debugSeed_q <= 1'b0;
    end
    else
    begin
      control_q <= control_d;
      key_q <= key_d;
      if (loadDone)
        debugSeed_q <= 1'b1;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      readValid_q <= 1'b0;
      readData_q <= 32'h0;
    end
    else
    begin
      readValid_q <= avReq.read & ~readValid_q;
      if (avReq.read && !readValid_q)
        readData_q <= readMux;
    end
  end
  assign avRsp.waitrequest = avReq.read & ~readValid_q;
  assign avRsp.readdata = readData_q;
  // ****************************************
  // Decoded outputs
  // ****************************************
  assign moduleDisableWriteEn = ~control_q[`DCW_CC_LOCK];
  assign configReady = loadDone;
  assign ctl.codeProtect = codeProtect;
  assign ctl.bootWriteProtect = bootWriteProtect;
  assign ctl.debugPortEnable = control_q[`DCW_CC_DEBUG_EN];
  assign ctl.traceOutputEnable = HAS_TRACE & control_q[`DCW_CC_TRACE_EN];
  assign ctl.moduleDisableLock = control_q[`DCW_CC_LOCK];
  assign ctl.usbPllEnable = HAS_USB & loadDone & word2[`DCW_W2_USB_PLL_EN];
  assign ctl.usbPllInputDivider = (HAS_USB && loadDone) ?
    word2[`DCW_W2_USB_DIV_HI:`DCW_W2_USB_DIV_LO] : 3'h0;
endmodule

// *** dcw_cfg.svh ***
// Register offsets, field positions and reset values of the configuration word block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef DCW_CFG_SVH
`define DCW_CFG_SVH
// ****************************************
// Byte offsets
// ****************************************
`define DCW_OFS_WORD0 16'h0bfc
`define DCW_OFS_WORD1 16'h0bf8
`define DCW_OFS_WORD2 16'h0bf4
`define DCW_OFS_WORD3 16'h0bf0
`define DCW_OFS_CONTROL 16'hf200
`define DCW_OFS_PARTID 16'hf220
`define DCW_OFS_KEY 16'hf230
`define DCW_OFS_LOADSTAT 16'hf240
// ****************************************
// Field positions
// ****************************************
`define DCW_W0_CODE_PROT 28
`define DCW_W0_BOOT_WP 24
`define DCW_W0_DEBUG_EN 2
`define DCW_W2_USB_PLL_EN 15
`define DCW_W2_USB_DIV_LO 8
`define DCW_W2_USB_DIV_HI 10
`define DCW_CC_LOCK 12
`define DCW_CC_DEBUG_EN 3
`define DCW_CC_TRACE_EN 2
`define DCW_CC_TDO_EN 0
`define DCW_CC_IO_LOCK 13
// ****************************************
// Reset values and masks
// ****************************************
`define DCW_CC_RESET 32'h0000000b
`define DCW_CC_WMASK 32'h00003005
`define DCW_KEY_RESET 32'h00000000
`define DCW_PART_ID 12'h5a5
`define DCW_REVISION 4'h1
`define DCW_NV_WORDS 4
`define DCW_LOAD_WAIT 8'h03
`endif

// *** dcw_pkg.sv ***
// Types shared by the configuration word block.
// Assumes dcw_cfg.svh sits in the same folder.
package dcw_pkg;
  typedef struct packed {
    logic [15:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } dcw_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } dcw_rsp_t;
  typedef struct packed {
    logic codeProtect;
    logic bootWriteProtect;
    logic debugPortEnable;
    logic traceOutputEnable;
    logic moduleDisableLock;
    logic usbPllEnable;
    logic [2:0] usbPllInputDivider;
  } dcw_ctl_t;
endpackage

// *** dcw_nv_loader.sv ***
// Loads the configuration words from the nonvolatile array after reset.
// Assumes an array that answers a read strobe one cycle later.
`include "dcw_cfg.svh"
module dcw_nv_loader (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  output logic nvRead, // Read strobe to the array
  output logic [1:0] nvIndex, // Word index to the array
  input wire logic [31:0] nvData, // Word from the array
  output logic [127:0] words, // Loaded words, word 0 lowest
  output logic loadDone // All words present
);
  import dcw_pkg::*;
  typedef enum logic [1:0] {DCW_WAIT, DCW_ISSUE, DCW_TAKE, DCW_DONE} dcw_state_t;
  dcw_state_t state_q, state_d;
  logic [7:0] wait_q;
  logic [1:0] index_q;
  logic [127:0] words_q;
  wire lastWord = (index_q == 2'(`DCW_NV_WORDS - 1));
  assign nvRead = (state_q == DCW_ISSUE);
  assign nvIndex = index_q;
  assign words = words_q;
  assign loadDone = (state_q == DCW_DONE);
  always_comb
  begin
    case (state_q)
      DCW_WAIT: state_d = (wait_q == 8'h00) ? DCW_ISSUE : DCW_WAIT;
      DCW_ISSUE: state_d = DCW_TAKE;
      DCW_TAKE: state_d = lastWord ? DCW_DONE : DCW_ISSUE;
      DCW_DONE: state_d = DCW_DONE;
      default: state_d = DCW_WAIT;
    endcase
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= DCW_WAIT;
      wait_q <= `DCW_LOAD_WAIT;
      index_q <= 2'h0;
      words_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == DCW_WAIT)
        wait_q <= wait_q - 8'h01;
      if (state_q == DCW_TAKE)
      begin
        words_q[index_q*32 +: 32] <= nvData;
        index_q <= index_q + 2'h1;
      end
    end
  end
endmodule

// *** dcw_device_config_monitor.sv ***
// Checker for the configuration word block, bound to its top module.
// Assumes dcw_pkg and dcw_cfg.svh are compiled alongside.
`include "dcw_cfg.svh"
module dcw_cfg_monitor (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire dcw_pkg::dcw_req_t avReq, // Bus request
  input wire dcw_pkg::dcw_rsp_t avRsp, // Bus answer
  input wire logic nvRead, // Array strobe
  input wire logic extProgRead, // Programmer read
  input wire logic extProgWrite, // Programmer write
  input wire logic cpuBootWrite, // Boot write request
  input wire logic extProgGrant, // Programmer grant
  input wire logic cpuBootGrant, // Boot write grant
  input wire logic moduleDisableWriteEn, // Module disable writable
  input wire dcw_pkg::dcw_ctl_t ctl, // Decoded configuration
  input wire logic configReady // Words loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  import dcw_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ansRd = avReq.read && !avRsp.waitrequest;
  sequence s_rd_start;
    $rose(avReq.read);
  endsequence
  sequence s_rd_answer;
    avRsp.waitrequest ##1 !avRsp.waitrequest;
  endsequence
  a_read_wait: assert property (s_rd_start |-> s_rd_answer)
    else $error("read answer timing wrong");
  a_prog_grant: assert property (extProgGrant |-> configReady && (extProgRead || extProgWrite))
    else $error("programmer grant without cause");
  a_boot_grant: assert property (cpuBootGrant |-> configReady && cpuBootWrite)
    else $error("boot write grant without cause");
  a_lock_enable: assert property (moduleDisableWriteEn == !ctl.moduleDisableLock)
    else $error("lock and write enable disagree");
  a_load_pulse: assert property (nvRead |=> !nvRead)
    else $error("array strobe longer than a cycle");
  a_ready_hold: assert property (configReady |=> configReady)
    else $error("ready dropped");
  a_id_value: assert property (ansRd && avReq.address == `DCW_OFS_PARTID |->
    avRsp.readdata == {`DCW_REVISION, `DCW_PART_ID, 16'h0000})
    else $error("identification value wrong");
  a_ctl_zero: assert property (ansRd && avReq.address == `DCW_OFS_CONTROL |->
    avRsp.readdata[31:14] == 18'h00000)
    else $error("unused control bits not zero");
endmodule
bind dcw_device_config dcw_cfg_monitor u_mon (.clk(clk), .rst(rst), .avReq(avReq),
  .avRsp(avRsp), .nvRead(nvRead), .extProgRead(extProgRead), .extProgWrite(extProgWrite),
  .cpuBootWrite(cpuBootWrite), .extProgGrant(extProgGrant), .cpuBootGrant(cpuBootGrant),
  .moduleDisableWriteEn(moduleDisableWriteEn), .ctl(ctl), .configReady(configReady));

// *** dcw_device_config_tb.sv ***
// Self-checking bench for the configuration word block, two load passes.
// Assumes the design files and dcw_cfg.svh are compiled first.
`include "dcw_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("Error %0t: got %h want %h", $time, (g), (e)); end end
module dcw_device_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dcw_pkg::*;
  logic clk, rst, nvRead, extProgRead, extProgWrite, cpuBootWrite;
  logic extProgGrant, cpuBootGrant, moduleDisableWriteEn, configReady;
  logic [1:0] nvIndex;
  logic [31:0] nvData, rdat, jt;
  logic [31:0] w [4];
  dcw_req_t avReq;
  dcw_rsp_t avRsp;
  dcw_ctl_t ctl;
  dcw_rsp_t avRsp2;
  dcw_ctl_t ctl2;
  int fails, n_compared;
  dcw_device_config DUT (.clk(clk), .rst(rst), .avReq(avReq), .avRsp(avRsp),
    .nvRead(nvRead), .nvIndex(nvIndex), .nvData(nvData), .extProgRead(extProgRead),
    .extProgWrite(extProgWrite), .cpuBootWrite(cpuBootWrite), .extProgGrant(extProgGrant),
    .cpuBootGrant(cpuBootGrant), .moduleDisableWriteEn(moduleDisableWriteEn), .ctl(ctl),
    .configReady(configReady));
  // Small variant without trace pin or USB, fed the same bus and array traffic
  dcw_device_config #(.HAS_TRACE(1'b0), .HAS_USB(1'b0)) DUT_small (.clk(clk), .rst(rst),
    .avReq(avReq), .avRsp(avRsp2), .nvRead(), .nvIndex(), .nvData(nvData),
    .extProgRead(extProgRead), .extProgWrite(extProgWrite), .cpuBootWrite(cpuBootWrite),
    .extProgGrant(), .cpuBootGrant(), .moduleDisableWriteEn(), .ctl(ctl2),
    .configReady());
  // ****************************************
  // Clock, array and bus tasks
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Array bus scrambles outside answers so stale data cannot pass
  always @(posedge clk) nvData <= nvRead ? w[nvIndex] : ~nvData;
  // Waits as long as the slave asks; only the watchdog ends a hung transfer
  task xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    avReq <= '{address: a, read: !wr, write: wr, writedata: d};
    do @(posedge clk); while (avRsp.waitrequest !== 1'b0);
    rdat = avRsp.readdata;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask
  task rd_chk(input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #50000;
    fails++;
    give_verdict;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {rst, extProgRead, extProgWrite, cpuBootWrite} = 4'hf;
    avReq = '0;
    // Pass 1 clears protect and debug bits; a second reset in mid-run reloads
    for (int p = 0; p < 2; p++)
    begin
      w = '{p ? 32'h6efffffb : 32'h7fffffff, 32'hffffffff, 32'h00008500, 32'h0000abcd};
      jt = p ? 32'h0 : 32'h8;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      {extProgRead, extProgWrite, cpuBootWrite} <= 3'h0;
      rd_chk(`DCW_OFS_KEY, `DCW_KEY_RESET);
      rd_chk(`DCW_OFS_CONTROL, `DCW_CC_RESET);
      for (int n = 0; n < 50 && configReady !== 1'b1; n++) @(posedge clk);
      `CHK(configReady, 1'b1)
      rd_chk(`DCW_OFS_WORD0, w[0]);
      xfer(1'b1, `DCW_OFS_WORD0, 32'h0);
      rd_chk(`DCW_OFS_WORD0, w[0]);
      rd_chk(`DCW_OFS_WORD2, w[2]);
      `CHK(avRsp2.readdata, 32'h0)
      rd_chk(`DCW_OFS_WORD3, w[3]);
      rd_chk(`DCW_OFS_PARTID, {`DCW_REVISION, `DCW_PART_ID, 16'h0000});
      rd_chk(`DCW_OFS_CONTROL, 32'h3 | jt);
      `CHK(ctl.debugPortEnable, jt[3])
      rd_chk(16'h1000, 32'h0);
      rd_chk(`DCW_OFS_LOADSTAT, 32'h1);
      xfer(1'b1, `DCW_OFS_KEY, 32'h5a5aa5a5);
      rd_chk(`DCW_OFS_KEY, 32'h5a5aa5a5);
      xfer(1'b1, `DCW_OFS_CONTROL, 32'hfffffff7 | jt);
      rd_chk(`DCW_OFS_CONTROL, 32'h3007 | jt);
      `CHK(avRsp2.readdata, 32'h3003 | jt)
      `CHK(moduleDisableWriteEn, 1'b0)
      `CHK(ctl.moduleDisableLock, 1'b1)
      `CHK(ctl.traceOutputEnable, 1'b1)
      `CHK(ctl2.traceOutputEnable, 1'b0)
      xfer(1'b1, `DCW_OFS_CONTROL, jt);
      rd_chk(`DCW_OFS_CONTROL, 32'h2 | jt);
      `CHK(moduleDisableWriteEn, 1'b1)
      `CHK(ctl.usbPllInputDivider, 3'h5)
      `CHK(ctl.usbPllEnable, 1'b1)
      `CHK(ctl2.usbPllEnable, 1'b0)
      `CHK(ctl2.usbPllInputDivider, 3'h0)
      `CHK(ctl.codeProtect, ~jt[3])
      `CHK(ctl.bootWriteProtect, ~jt[3])
      {extProgRead, cpuBootWrite} <= 2'h3;
      @(posedge clk);
      #1;
      `CHK(extProgGrant, jt[3])
      `CHK(cpuBootGrant, jt[3])
      {extProgRead, extProgWrite, cpuBootWrite} <= 3'h2;
      @(posedge clk);
      #1;
      `CHK(extProgGrant, jt[3])
      `CHK(cpuBootGrant, 1'b0)
    end
    give_verdict;
  end
endmodule
